// ### psgd_core.sv
/*
  gate drive control of a buck power stage: decodes the three-level pwm command
  and the diode-emulation control into high and low gate enables, with tristate
  hold-off, adaptive dead time, zero-current turn-off, standby and supply lockout.
  assumes all pin-side inputs are asynchronous and reach the block as codes from
  comparators; gate-low reports come from the gate sense comparators (< 1 V).
*/
`timescale 1ns/100ps

// Function
// [R1] The pwm command is accepted both as a two-level and as a three-level code with a mid state.
// [R2] A decoded high command turns the high gate drive on.
// [R3] A decoded low command turns the high gate drive off and the low gate drive on.
// [R4] A command held at mid level for the hold-off period turns both gate drives off.
// [R5] In shutdown the controller floats its output and the pin is pulled to mid level.
// [R6] A low diode-emulation control permits diode emulation.
// [R7] A high diode-emulation control forces continuous conduction with the low side on.
// [R8] With diode emulation active, a zero inductor current turns the low gate drive off; at a mid command the code holds it on until the hold-off expires.
// [R9] A change of the diode-emulation control acts at once, not aligned to pwm edges.
// [R10] Mid on both the diode-emulation control and the command enters deep standby with gates off.
// [R11] The high and low gate drives are never on together.
// [R12] A gate drive is enabled only after the opposite gate is reported below 1 V.
// [R13] A fixed delay follows every turn-off before the other switch may turn on.
// [R14] While the supply lockout is asserted at start-up both gate drives stay low.
// [R15] Lockout on a falling supply forces both gate drives to zero at once.
// [R16] The block receives the command and the control input as low, high or mid codes.
module psgd_core
  import psgd_pkg::*;
#(
  parameter int HOLDOFF_CNT = HOLDOFF_CYCLES,
  parameter int BREAK_CNT   = BREAK_DELAY_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire psgd_level_e pwmLevel,
  input  wire psgd_level_e diodeEmuLevel,
  input  wire logic        zeroCurrent,
  input  wire logic        highGateLow,
  input  wire logic        lowGateLow,
  input  wire logic        supplyLockout,
  output psgd_gates_s      gates,
  output logic             deepStandbyState,
  output logic             inLockout
);

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  logic [1:0] pwmSync;
  logic [1:0] demSync;
  logic       zeroSync;
  logic       hgLowSync;
  logic       lgLowSync;
  logic       lockSync;

  // lockout resets asserted so the gates stay off until the supply is reported good
  psgd_sync #(.WIDTH(2), .RESET_VAL(2'h2)) uPwmSync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn (pwmLevel),
    .syncOut (pwmSync)
  ); // R1 R16
  psgd_sync #(.WIDTH(2), .RESET_VAL(2'h2)) uDemSync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn (diodeEmuLevel),
    .syncOut (demSync)
  ); // R16
  psgd_sync #(.WIDTH(4), .RESET_VAL(4'hF)) uMiscSync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn ({zeroCurrent, highGateLow, lowGateLow, supplyLockout}),
    .syncOut ({zeroSync, hgLowSync, lgLowSync, lockSync})
  );

  psgd_level_e pwmCode;
  psgd_level_e demCode;
  logic        pwmIllegal;
  logic        demIllegal;

  // an unused code 3 is treated as mid, the safe state
  assign pwmIllegal = (pwmSync == 2'h3);
  assign demIllegal = (demSync == 2'h3);
  assign pwmCode    = pwmIllegal ? LVL_MID : psgd_level_e'(pwmSync);
  assign demCode    = demIllegal ? LVL_MID : psgd_level_e'(demSync);

  ////////////////////////////////////////////////////////////////////////////////
  // tristate hold-off timer

  logic [CNT_W-1:0] holdCnt_q;
  logic             holdExpired;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      holdCnt_q <= '0;
    end else if (pwmCode != LVL_MID) begin
      holdCnt_q <= '0;
    end else if (!holdExpired) begin
      holdCnt_q <= holdCnt_q + CNT_W'(1); // R4
    end
  end

  // pin pull to mid is analog; the block sees a floated command as mid code
  assign holdExpired = (holdCnt_q >= CNT_W'(HOLDOFF_CNT - 1)); // R4 R5

  ////////////////////////////////////////////////////////////////////////////////
  // break-before-make delay

  logic [CNT_W-1:0] breakCnt_q;
  logic             breakDone;
  logic             anyGateOn;

  // counter restarts while any gate is commanded on, runs after both are off
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      breakCnt_q <= '0;
    end else if (anyGateOn) begin
      breakCnt_q <= '0;
    end else if (!breakDone) begin
      breakCnt_q <= breakCnt_q + CNT_W'(1); // R13
    end
  end

  assign breakDone = (breakCnt_q >= CNT_W'(BREAK_CNT)); // R13

  ////////////////////////////////////////////////////////////////////////////////
  // main state machine

  psgd_state_e state_q;
  psgd_state_e state_d;
  logic        wantHigh;
  logic        wantLow;
  logic        demAllowed;
  logic        standbyReq;

  assign standbyReq = (demCode == LVL_MID) && (pwmCode == LVL_MID); // R10
  assign demAllowed = (demCode == LVL_LOW);                           // R6 R7
  assign wantHigh   = (pwmCode == LVL_HIGH);                          // R2
  // low side follows a low command unless emulation sees zero current
  assign wantLow    = (pwmCode == LVL_LOW) && !(demAllowed && zeroSync); // R3 R7 R8 R9

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_LOCKOUT: begin
        if (!lockSync) begin
          state_d = ST_IDLE; // R14
        end
      end
      ST_IDLE: begin
        if (standbyReq) begin
          state_d = ST_STANDBY;
        end else if (wantHigh) begin
          state_d = ST_WAIT_HI;
        end else if (wantLow) begin
          state_d = ST_WAIT_LO;
        end
      end
      ST_WAIT_HI: begin
        if (!wantHigh) begin
          state_d = ST_IDLE;
        end else if (breakDone && lgLowSync) begin
          state_d = ST_HIGH; // R12 R13
        end
      end
      ST_HIGH: begin
        if (!wantHigh && (pwmCode != LVL_MID || holdExpired)) begin
          state_d = ST_IDLE; // R3 R4
        end
      end
      ST_WAIT_LO: begin
        if (!wantLow) begin
          state_d = ST_IDLE;
        end else if (breakDone && hgLowSync) begin
          state_d = ST_LOW; // R12 R13
        end
      end
      ST_LOW: begin
        if (pwmCode == LVL_MID) begin
          if (holdExpired) begin
            state_d = ST_IDLE; // R4
          end
        end else if (!wantLow) begin
          state_d = ST_IDLE; // R8 R9
        end
      end
      ST_STANDBY: begin
        if (!standbyReq) begin
          state_d = ST_IDLE; // R10
        end
      end
      default: state_d = ST_LOCKOUT;
    endcase
    // lockout overrides every state at once
    if (lockSync) begin
      state_d = ST_LOCKOUT; // R14 R15
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_LOCKOUT;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registered outputs

  psgd_gates_s gates_d;

  always_comb begin
    gates_d               = '0;
    gates_d.highGateDrive = (state_d == ST_HIGH);
    gates_d.lowGateDrive  = (state_d == ST_LOW);
    if (gates_d.highGateDrive && gates_d.lowGateDrive) begin
      gates_d = '0; // R11
    end
  end

  // uses the next state so the break counter restarts the same edge a gate opens
  assign anyGateOn = gates_d.highGateDrive || gates_d.lowGateDrive;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gates <= '0; // R14
    end else begin
      gates <= gates_d; // R11 R15
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      deepStandbyState <= 1'b0;
      inLockout        <= 1'b1;
    end else begin
      deepStandbyState <= (state_d == ST_STANDBY); // R10
      inLockout        <= (state_d == ST_LOCKOUT);
    end
  end

endmodule : psgd_core

// ### psgd_pkg.sv
/*
  package of the power-stage gate drive logic: three-level input codes, states,
  and timing constants derived from the 125 MHz block clock.
  assumes comparators upstream already reduce the analog pins to three-level codes.
*/
package psgd_pkg;

  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_HIGH = 2'h1,
    LVL_MID  = 2'h2
  } psgd_level_e;

  typedef enum logic [2:0] {
    ST_LOCKOUT = 3'h0,
    ST_IDLE    = 3'h1,
    ST_WAIT_HI = 3'h2,
    ST_HIGH    = 3'h3,
    ST_WAIT_LO = 3'h4,
    ST_LOW     = 3'h5,
    ST_STANDBY = 3'h6
  } psgd_state_e;

  typedef struct packed {
    logic highGateDrive;
    logic lowGateDrive;
  } psgd_gates_s;

  localparam int CLK_PERIOD_PS       = 8000;
  // tristate hold-off, picoseconds: least, typical, longest
  localparam int HOLDOFF_MIN_PS      = 85000;
  localparam int HOLDOFF_TYP_PS      = 150000;
  localparam int HOLDOFF_MAX_PS      = 225000;
  localparam int HOLDOFF_CYCLES      = HOLDOFF_TYP_PS / CLK_PERIOD_PS;
  // built-in delay after a switch turns off before the other may turn on
  localparam int BREAK_DELAY_PS      = 10000;
  localparam int BREAK_DELAY_CYCLES  = (BREAK_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W               = 8;
  localparam int SYNC_STAGES         = 3;

endpackage : psgd_pkg

// ### psgd_sync.sv
/*
  three-stage synchroniser with agreement filter for an asynchronous bus of bits.
  assumes the input comes from outside the clock domain; output changes only
  once the second and third stages agree.
*/
`timescale 1ns/100ps
module psgd_sync
  import psgd_pkg::*;
#(
  parameter int        WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1_q <= RESET_VAL;
      stage2_q <= RESET_VAL;
      stage3_q <= RESET_VAL;
      syncOut  <= RESET_VAL;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      if (stage2_q == stage3_q) begin
        syncOut <= stage3_q;
      end
    end
  end

endmodule : psgd_sync

// ### psgd_props.sv
/* checker of the gate drive outputs.
   assumes pin inputs stay steady for several cycles per step. */
`timescale 1ns/100ps
module psgd_props
  import psgd_pkg::*;
#(parameter int HOLDOFF_CNT = HOLDOFF_CYCLES) (
  input wire logic        clk,
  input wire logic        reset,
  input wire psgd_level_e pwmLevel,
  input wire psgd_level_e diodeEmuLevel,
  input wire logic        zeroCurrent,
  input wire logic        highGateLow,
  input wire logic        lowGateLow,
  input wire logic        supplyLockout,
  input wire psgd_gates_s gates,
  input wire logic        deepStandbyState,
  input wire logic        inLockout
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  localparam int HOLD_MIN_CYC = HOLDOFF_MIN_PS / CLK_PERIOD_PS;
  int midRun;
  // run length of the mid code; margin below covers the synchroniser
  always_ff @(posedge clk or posedge reset) begin
    if (reset) midRun <= 0;
    else midRun <= pwmLevel[1] ? midRun + 1 : 0;
  end
  //////////////////////////////////////////
  chk_no_overlap:
    assert property (!(gates.highGateDrive && gates.lowGateDrive)) else $error("both on");
  chk_lockout_off:
    assert property ($rose(supplyLockout) |-> ##[1:7] (gates == '0 && inLockout))
      else $error("lockout late");
  chk_lockout_hold:
    assert property (inLockout |-> gates == '0) else $error("gate on in lockout");
  chk_break_delay:
    assert property ($rose(gates.highGateDrive) |-> !$past(gates.lowGateDrive, 2))
      else $error("no break delay");
  chk_sense_wait:
    assert property ($rose(gates.lowGateDrive) |-> $past(highGateLow, 2))
      else $error("low on before sense");
  chk_holdoff_off:
    assert property (midRun == HOLDOFF_CNT + 8 |-> gates == '0) else $error("holdoff");
  chk_holdoff_min:
    assert property (gates.highGateDrive && pwmLevel == LVL_MID && midRun < HOLD_MIN_CYC
      && diodeEmuLevel != LVL_MID && !supplyLockout |=> gates.highGateDrive)
      else $error("holdoff too short");
  chk_standby_entry:
    assert property ((pwmLevel == LVL_MID && diodeEmuLevel == LVL_MID) [*8]
      |-> deepStandbyState && gates == '0) else $error("no standby");
  chk_ccm_low:
    assert property ((pwmLevel == LVL_LOW && diodeEmuLevel == LVL_HIGH && highGateLow
      && !supplyLockout) [*8] |-> ##[0:12] gates.lowGateDrive) else $error("low off");
  chk_zero_cut:
    assert property ((diodeEmuLevel == LVL_LOW && zeroCurrent) [*8]
      |-> !gates.lowGateDrive) else $error("zero cut missed");
endmodule : psgd_props
bind psgd_core psgd_props #(.HOLDOFF_CNT(HOLDOFF_CNT)) i_psgd_props (.clk(clk),
  .reset(reset), .pwmLevel(pwmLevel), .diodeEmuLevel(diodeEmuLevel),
  .zeroCurrent(zeroCurrent), .highGateLow(highGateLow), .lowGateLow(lowGateLow),
  .supplyLockout(supplyLockout), .gates(gates), .deepStandbyState(deepStandbyState),
  .inLockout(inLockout));

// ### psgd_ctrl_model.sv
/* controller and gate-sense model on the far side of the gate drive block.
   assumes the bench sets the wanted command and any sense fault. */
`timescale 1ns/100ps
module psgd_ctrl_model
  import psgd_pkg::*;
(
  input  wire logic        clk,
  input  wire psgd_level_e cmd,
  input  wire logic        floatOut,
  input  wire logic        slow,
  input  wire logic        stuckHigh,
  input  wire psgd_gates_s gates,
  output psgd_level_e      pwmLevel,
  output logic             highGateLow,
  output logic             lowGateLow
);
  logic [3:0] hiCnt = '0;
  logic [3:0] loCnt = '0;
  wire  [3:0] lim   = slow ? 4'h6 : 4'h1;
  // a released output is pulled into the mid band
  assign pwmLevel = floatOut ? LVL_MID : cmd;
  always_ff @(posedge clk) hiCnt <= gates.highGateDrive ? '0 : hiCnt + {3'h0, hiCnt < lim};
  always_ff @(posedge clk) loCnt <= gates.lowGateDrive ? '0 : loCnt + {3'h0, loCnt < lim};
  // stuck sense stands for a gate that never discharges
  assign highGateLow = !stuckHigh && hiCnt >= lim;
  assign lowGateLow  = loCnt >= lim;
endmodule : psgd_ctrl_model

// ### testbench.sv
/* self-checking bench of the gate drive core with its controller model.
   assumes core outputs settle well within half a clock period. */
`timescale 1ns/100ps
module testbench;
  import psgd_pkg::*;
  logic        clk, reset, zeroCurrent, supplyLockout, floatOut, slow, stuckHigh, started;
  logic        highGateLow, lowGateLow, deepStandbyState, inLockout;
  psgd_level_e cmd, nxt, diodeEmuLevel, pwmLevel;
  psgd_gates_s gates;
  logic [3:0]  expQ[$];
  logic [3:0]  prevRes;
  int          numErrors, checkCount, cycles;
  psgd_core i_psgd_core (.clk(clk), .reset(reset), .pwmLevel(pwmLevel),
    .diodeEmuLevel(diodeEmuLevel), .zeroCurrent(zeroCurrent), .highGateLow(highGateLow),
    .lowGateLow(lowGateLow), .supplyLockout(supplyLockout), .gates(gates),
    .deepStandbyState(deepStandbyState), .inLockout(inLockout));
  psgd_ctrl_model i_psgd_ctrl_model (.clk(clk), .cmd(cmd), .floatOut(floatOut),
    .slow(slow), .stuckHigh(stuckHigh), .gates(gates), .pwmLevel(pwmLevel),
    .highGateLow(highGateLow), .lowGateLow(lowGateLow));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  //////////////////////////////////////////
  task automatic finishTest;
    $display("errors %0d checks %0d", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finishTest
  task automatic fail(input string m);
    numErrors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : fail
  // every noted change must have shown up by the end of the wait
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    checkCount++;
    if (expQ.size() != 0) fail("missing change");
    expQ.delete();
    #1;
  endtask : settle
  task automatic step(input psgd_level_e lv);
    if (lv != cmd) begin
      expQ.push_back(4'h0);
      expQ.push_back(lv == LVL_HIGH ? 4'h8 : 4'h4);
    end
    cmd = lv;
    settle(40);
  endtask : step
  // outputs read at the falling edge, clear of the launching edge
  always @(negedge clk) begin
    if (started && {gates, deepStandbyState, inLockout} !== prevRes) begin
      checkCount++;
      if (expQ.size() == 0 || expQ[0] !== {gates, deepStandbyState, inLockout})
        fail("bad change");
      if (expQ.size() != 0) void'(expQ.pop_front());
    end
    prevRes = {gates, deepStandbyState, inLockout};
    cycles++;
    if (cycles == 3000) begin
      fail("timeout");
      finishTest();
    end
  end
  initial begin
    {reset, supplyLockout} = 2'h3;
    {zeroCurrent, floatOut, slow, stuckHigh, started} = 5'h00;
    cmd = LVL_LOW;
    diodeEmuLevel = LVL_HIGH;
    {numErrors, checkCount, cycles} = '0;
    prevRes = 4'h1;
    void'($urandom(32'h224E99B2));
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    started = 1'b1;
    settle(10);
    expQ.push_back(4'h0);
    expQ.push_back(4'h4);
    supplyLockout = 1'b0;
    settle(30);
    for (int i = 0; i < 8; i++) begin
      nxt = $urandom_range(1) ? LVL_HIGH : LVL_LOW;
      slow = 1'($urandom_range(1));
      // zero current is random only under forced conduction, where it must not matter
      diodeEmuLevel = $urandom_range(1) ? LVL_HIGH : LVL_LOW;
      zeroCurrent = (diodeEmuLevel == LVL_HIGH) && ($urandom_range(1) != 0);
      step(nxt);
    end
    step(LVL_HIGH);
    stuckHigh = 1'b1;
    expQ.push_back(4'h0);
    cmd = LVL_LOW;
    settle(40);
    stuckHigh = 1'b0;
    expQ.push_back(4'h4);
    settle(30);
    expQ.push_back(4'h0);
    diodeEmuLevel = LVL_LOW;
    zeroCurrent = 1'b1;
    settle(30);
    expQ.push_back(4'h4);
    zeroCurrent = 1'b0;
    settle(30);
    diodeEmuLevel = LVL_HIGH;
    step(LVL_HIGH);
    expQ.push_back(4'h0);
    floatOut = 1'b1;
    settle(40);
    expQ.push_back(4'h2);
    diodeEmuLevel = LVL_MID;
    settle(30);
    expQ.push_back(4'h0);
    diodeEmuLevel = LVL_HIGH;
    settle(30);
    expQ.push_back(4'h4);
    cmd = LVL_LOW;
    floatOut = 1'b0;
    settle(30);
    expQ.push_back(4'h1);
    supplyLockout = 1'b1;
    settle(20);
    expQ.push_back(4'h0);
    expQ.push_back(4'h4);
    supplyLockout = 1'b0;
    settle(30);
    // a second reset in mid-run must bring the block back through lockout
    expQ.push_back(4'h1);
    reset = 1'b1;
    settle(2);
    reset = 1'b0;
    expQ.push_back(4'h0);
    expQ.push_back(4'h4);
    settle(30);
    finishTest();
  end
endmodule : testbench
